// *** core/cmw_pkg.sv ***
/*
 * constants, field layouts and carrier types of the core memory word access block.
 * assumes a 250 MHz pclk and a 32-bit APB register port.
 */
package cmw_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 13;
    localparam int APB_AW = 8;
    localparam int ADDR_LSB = 1;
    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [APB_AW-1:0] CTRL_OFF = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_OFF = 8'h04;
    localparam logic [APB_AW-1:0] STAT_OFF = 8'h08;
    localparam logic [APB_AW-1:0] DATA_OFF = 8'h0c;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_8K_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    // -------------------------------------------------------------
    // word address field positions (index n-1 holds address bit n)
    // -------------------------------------------------------------
    localparam int YS_D_LSB = 0;
    localparam int YS_BLK = 2;
    localparam int YD_D_LSB = 3;
    localparam int YD_BLK = 5;
    localparam int XS_D_LSB = 6;
    localparam int XS_BLK = 8;
    localparam int XD_D_LSB = 9;
    localparam int XD_BLK = 11;
    localparam int A13_IDX = 12;
    // -------------------------------------------------------------
    // decoder banks: y switch, y driver, x switch, x driver
    // -------------------------------------------------------------
    localparam int GRP_N = 4;
    localparam int DEC_N = 10;
    localparam int YD_BASE = 2;
    localparam int XS_BASE = 4;
    localparam int XD_BASE = 8;
    localparam logic [7:0] DEC_IDLE = 8'hff;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int T_CLEAR_NS = 20;
    localparam int T_READ_NS = 200;
    localparam int T_STROBE_NS = 20;
    localparam int T_WRITE_NS = 200;
    localparam int CLEAR_CYC = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_CYC = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        SQ_IDLE, SQ_LATCH, SQ_LOAD, SQ_CLEAR, SQ_READ, SQ_STROBE, SQ_WRITE
    } cmw_phase_t;
    typedef struct packed {
        logic gate;
        logic clear;
        logic strobe;
        logic drive;
        logic load;
        logic inhibit;
        logic read_n;
    } cmw_pulses_t;
    typedef struct packed {
        logic [1:0] d_sel;
        logic read_n;
        logic blk_n;
    } cmw_dec_in_t;
    typedef struct packed {
        logic [7:0] out_n;
    } cmw_dec_state_t;
    typedef struct packed {
        cmw_phase_t phase;
        logic [7:0] cnt;
        logic cyc_wr;
        logic ctrl_wr;
        logic size8k;
        logic done;
        logic [ADDR_W-1:0] addr_reg;
        logic [ADDR_W-1:0] addr_ff;
        logic [WORD_W-1:0] data;
        cmw_pulses_t pulses;
        logic [WORD_W-1:0] bus_oe;
        logic [WORD_W-1:0] bus_out;
        logic [WORD_W-1:0] inhibit;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cmw_state_t;
    localparam cmw_state_t ST_RST = '{
        phase: SQ_IDLE,
        pulses: '{read_n: 1'b1, default: 1'b0},
        default: '0
    };
endpackage : cmw_pkg

// *** core/cmw_sel_decoder.sv ***
/*
 * one-of-eight drive line selection decoder with registered active-low outputs.
 * assumes its select inputs come from the word access sequencer on pclk.
 */
`timescale 1ns/100ps
`default_nettype none
module cmw_sel_decoder
    import cmw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire cmw_dec_in_t sel,
    output logic [7:0] out_n
);
    cmw_dec_state_t st_reg;
    cmw_dec_state_t st_next;

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    always_comb begin
        st_next.out_n = DEC_IDLE;
        // R4: block select low
        if (!sel.blk_n) begin
            // R5: mode picks half; R6/R7: low bits pick one of four
            st_next.out_n[{sel.read_n, sel.d_sel}] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.out_n <= DEC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_n = st_reg.out_n;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dec_idle;
        $past(sel.blk_n) |-> out_n == DEC_IDLE;
    endproperty
    a_dec_idle: assert property (p_dec_idle) else $error("decoder active without block select"); // R4

    property p_dec_pick;
        !$past(sel.blk_n) |-> out_n == ~(8'h01 << {$past(sel.read_n), $past(sel.d_sel)});
    endproperty
    a_dec_pick: assert property (p_dec_pick) else $error("decoder chose wrong output"); // R6

    property p_dec_half;
        !$past(sel.blk_n) && !$past(sel.read_n) |-> &out_n[7:4];
    endproperty
    a_dec_half: assert property (p_dec_half) else $error("write half active on read"); // R5
endmodule : cmw_sel_decoder
`default_nettype wire

// *** core/cmw_word_access.sv ***
/*
 * core memory word access: APB registers, address flops and gating, drive line
 * decoders, 16-bit core data register and the read/restore and write sequencer.
 * assumes sense and bus inputs are synchronous to pclk and the analog drivers
 * follow the decoder and inhibit outputs.
 */
// The APB register port and the address map were decided locally.
// Behaviour
// R1: word location comes from address bits 13..1 latched into address flops.
// R2: in 4K size, address bit 13 is strapped and ignored for selection.
// R3: address bits 6, 12, 13 reach decoders only ANDed with gate pulse.
// R4: a decoder drives an output only while its block select is low.
// R5: active-low read select feeds every decoder mode input; low picks read.
// R6: read select low picks outputs 0-3, high picks write outputs 4-7.
// R7: two low select bits choose one of four in the chosen half.
// R8: a sensed bit is one only when strobe meets a detected core pulse.
// R9: clear pulse empties the data register just before the strobe; the code clears it before the read phase, which runs between clear and strobe.
// R10: a sensed one sets its data register bit.
// R11: bus drive pulls a line low for a stored one, releases for zero.
// R12: every read is followed at once by a restoring write.
// R13: inhibit pulse turns on a bit's inhibit driver only for a zero.
// R14: read/restore rewrites the word by itself, requester does nothing more.
// R15: for a write the requester holds data on the bus lines.
// R16: load pulse takes the bus receivers into the register; no sensing.
// R17: write cycles keep clear and strobe idle; read phase only clears cores.
// R18: the bit path is replicated for all sixteen bits.
// R19: sequencer issues gate, clear, strobe, drive, load, inhibit in order; reads clear, gate, strobe, drive+inhibit, writes load, gate, inhibit.
`timescale 1ns/100ps
`default_nettype none
module cmw_word_access
    import cmw_pkg::*;
#(
    parameter int CLEAR_CYCLES = CLEAR_CYC,
    parameter int READ_CYCLES = READ_CYC,
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WORD_W-1:0] bus_data_n_in,
    output logic [WORD_W-1:0] bus_data_out,
    output logic [WORD_W-1:0] bus_data_oe,
    input wire logic [WORD_W-1:0] sense_pulse,
    output logic [WORD_W-1:0] inhibit_drive,
    output logic read_sel_n,
    output logic address_gate_pulse,
    output logic data_clear_pulse,
    output logic sense_strobe,
    output logic data_load_pulse,
    output logic inhibit_timing_pulse,
    output logic bus_drive_en,
    output logic [DEC_N-1:0][7:0] sel_lines_n
);
    cmw_state_t st_reg;
    cmw_state_t st_next;
    logic setup;
    logic access_wr;
    logic go;
    logic last;
    logic a06_g;
    logic a12_g;
    logic a13_g;
    logic [GRP_N-1:0][1:0] grp_d;
    logic [GRP_N-1:0][1:0] grp_blk;

    // -------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------
    assign setup = psel && !penable && !st_reg.pready;
    assign access_wr = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    assign go = access_wr && paddr == CTRL_OFF && pwdata[CTRL_GO_BIT];
    assign last = st_reg.cnt == 8'h00;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.cnt = last ? 8'h00 : st_reg.cnt - 8'h01;
        if (setup) begin
            st_next.pready = 1'b1;
            st_next.prdata = '0;
            case (paddr)
                CTRL_OFF: begin
                    st_next.prdata[CTRL_WR_BIT] = st_reg.ctrl_wr;
                    st_next.prdata[CTRL_8K_BIT] = st_reg.size8k;
                end
                ADDR_OFF: st_next.prdata[ADDR_LSB +: ADDR_W] = st_reg.addr_reg;
                STAT_OFF: begin
                    st_next.prdata[STAT_BUSY_BIT] = st_reg.phase != SQ_IDLE;
                    st_next.prdata[STAT_DONE_BIT] = st_reg.done;
                end
                DATA_OFF: st_next.prdata[WORD_W-1:0] = st_reg.data;
                default: st_next.pslverr = 1'b1;
            endcase
        end
        if (access_wr && paddr == CTRL_OFF) begin
            st_next.ctrl_wr = pwdata[CTRL_WR_BIT];
            st_next.size8k = pwdata[CTRL_8K_BIT];
        end
        if (access_wr && paddr == ADDR_OFF) begin
            st_next.addr_reg = pwdata[ADDR_LSB +: ADDR_W];
        end
        case (st_reg.phase)
            SQ_IDLE: begin
                // a start while busy is dropped, the cycle cannot be cut short
                if (go) begin
                    st_next.phase = SQ_LATCH;
                    st_next.cyc_wr = pwdata[CTRL_WR_BIT];
                    st_next.done = 1'b0;
                end
            end
            SQ_LATCH: begin
                // R1: capture word address
                st_next.addr_ff = st_reg.addr_reg;
                // R2: strapped receiver leaves bit 13 reset in 4K
                if (!st_reg.size8k) begin
                    st_next.addr_ff[A13_IDX] = 1'b0;
                end
                if (st_reg.cyc_wr) begin
                    st_next.phase = SQ_LOAD;
                end else begin
                    st_next.phase = SQ_CLEAR;
                    st_next.cnt = 8'(CLEAR_CYCLES - 1);
                end
            end
            SQ_LOAD: begin
                // R15: requester holds data; R16: load from receivers
                st_next.data = ~bus_data_n_in;
                st_next.phase = SQ_READ;
                st_next.cnt = 8'(READ_CYCLES - 1);
            end
            SQ_CLEAR: begin
                // R9: empty register ahead of strobe
                st_next.data = '0;
                if (last) begin
                    st_next.phase = SQ_READ;
                    st_next.cnt = 8'(READ_CYCLES - 1);
                end
            end
            SQ_READ: begin
                // R17: write cycle read only clears cores
                if (last && st_reg.cyc_wr) begin
                    st_next.phase = SQ_WRITE;
                    st_next.cnt = 8'(WRITE_CYCLES - 1);
                end else if (last) begin
                    st_next.phase = SQ_STROBE;
                    st_next.cnt = 8'(STROBE_CYCLES - 1);
                end
            end
            SQ_STROBE: begin
                // R8/R10/R18: strobed sense sets its bit
                st_next.data = st_reg.data | sense_pulse;
                // R12/R14: restore follows at once
                if (last) begin
                    st_next.phase = SQ_WRITE;
                    st_next.cnt = 8'(WRITE_CYCLES - 1);
                end
            end
            SQ_WRITE: begin
                if (last) begin
                    st_next.phase = SQ_IDLE;
                    st_next.done = 1'b1;
                end
            end
            default: st_next.phase = SQ_IDLE;
        endcase
        // R19: pulses follow the phase
        st_next.pulses.gate = st_next.phase inside {SQ_READ, SQ_STROBE, SQ_WRITE};
        st_next.pulses.clear = st_next.phase == SQ_CLEAR && !st_next.cyc_wr;
        st_next.pulses.strobe = st_next.phase == SQ_STROBE && !st_next.cyc_wr;
        st_next.pulses.load = st_next.phase == SQ_LOAD;
        st_next.pulses.inhibit = st_next.phase == SQ_WRITE;
        st_next.pulses.drive = st_next.phase == SQ_WRITE && !st_next.cyc_wr;
        // R5: read select low only while cores are read
        st_next.pulses.read_n = !(st_next.phase inside {SQ_READ, SQ_STROBE});
        // R11: stored one pulls its line low
        st_next.bus_oe = st_next.pulses.drive ? st_next.data : '0;
        st_next.bus_out = '0;
        // R13: zero bits inhibit the write
        st_next.inhibit = st_next.pulses.inhibit ? ~st_next.data : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // -------------------------------------------------------------
    // address gating and decoders
    // -------------------------------------------------------------
    // R3: gated address bits
    assign a06_g = st_reg.addr_ff[YD_BLK] & st_reg.pulses.gate;
    assign a12_g = st_reg.addr_ff[XD_BLK] & st_reg.pulses.gate;
    assign a13_g = st_reg.addr_ff[A13_IDX] & st_reg.pulses.gate;
    assign grp_d[0] = st_reg.addr_ff[YS_D_LSB +: 2];
    assign grp_d[1] = st_reg.addr_ff[YD_D_LSB +: 2];
    assign grp_d[2] = st_reg.addr_ff[XS_D_LSB +: 2];
    assign grp_d[3] = st_reg.addr_ff[XD_D_LSB +: 2];
    assign grp_blk[0] = {1'b0, st_reg.addr_ff[YS_BLK]};
    assign grp_blk[1] = {1'b0, a06_g};
    assign grp_blk[2] = {a13_g, st_reg.addr_ff[XS_BLK]};
    assign grp_blk[3] = {1'b0, a12_g};

    // every bank also waits for the gate pulse, so idle time drives no line
    for (genvar g = 0; g < DEC_N; g++) begin : g_dec
        localparam int GRP = g < YD_BASE ? 0 : g < XS_BASE ? 1 : g < XD_BASE ? 2 : 3;
        localparam int BASE = GRP == 0 ? 0 : GRP == 1 ? YD_BASE : GRP == 2 ? XS_BASE : XD_BASE;
        localparam logic [1:0] KIDX = 2'(g - BASE);
        cmw_dec_in_t din;
        assign din.d_sel = grp_d[GRP];
        assign din.read_n = st_reg.pulses.read_n;
        // R4: block select per bank
        assign din.blk_n = !(st_reg.pulses.gate && grp_blk[GRP] == KIDX);
        cmw_sel_decoder u_dec (
            .pclk(pclk),
            .presetn(presetn),
            .sel(din),
            .out_n(sel_lines_n[g])
        );
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign bus_data_out = st_reg.bus_out;
    assign bus_data_oe = st_reg.bus_oe;
    assign inhibit_drive = st_reg.inhibit;
    assign read_sel_n = st_reg.pulses.read_n;
    assign address_gate_pulse = st_reg.pulses.gate;
    assign data_clear_pulse = st_reg.pulses.clear;
    assign sense_strobe = st_reg.pulses.strobe;
    assign data_load_pulse = st_reg.pulses.load;
    assign inhibit_timing_pulse = st_reg.pulses.inhibit;
    assign bus_drive_en = st_reg.pulses.drive;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_a13_strap;
        $past(st_reg.phase == SQ_LATCH) && !$past(st_reg.size8k) |-> !st_reg.addr_ff[A13_IDX];
    endproperty
    a_a13_strap: assert property (p_a13_strap) else $error("bit 13 kept in 4K"); // R2

    property p_gate_off;
        !address_gate_pulse |=> sel_lines_n == {DEC_N{DEC_IDLE}};
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("line selected without gate"); // R3

    property p_sense_set;
        sense_strobe |=> (st_reg.data & $past(sense_pulse)) == $past(sense_pulse);
    endproperty
    a_sense_set: assert property (p_sense_set) else $error("sensed one not stored"); // R8

    property p_clear;
        data_clear_pulse |=> st_reg.data == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left bits set"); // R9

    property p_bus_drive;
        bus_drive_en |-> bus_data_oe == st_reg.data && bus_data_out == '0;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus drive mismatch"); // R11

    property p_restore;
        $fell(sense_strobe) |-> inhibit_timing_pulse && bus_drive_en;
    endproperty
    a_restore: assert property (p_restore) else $error("restore did not follow read"); // R12

    property p_inhibit;
        inhibit_timing_pulse ##1 inhibit_timing_pulse |-> inhibit_drive == ~$past(st_reg.data);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit not from zero bits"); // R13

    property p_load;
        data_load_pulse |=> st_reg.data == ~$past(bus_data_n_in);
    endproperty
    a_load: assert property (p_load) else $error("load missed bus data"); // R16

    property p_wr_quiet;
        st_reg.cyc_wr |-> !data_clear_pulse && !sense_strobe && !bus_drive_en;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("clear or strobe in write"); // R17

    property p_strobe_len;
        $rose(sense_strobe) |-> sense_strobe [*5] ##1 !sense_strobe;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong"); // R19

    property p_addr_latch;
        $past(st_reg.phase == SQ_LATCH) && $past(st_reg.size8k)
            |-> st_reg.addr_ff == $past(st_reg.addr_reg);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("word address not latched"); // R1

    property p_sel_one;
        address_gate_pulse |=> $countones(~sel_lines_n) == GRP_N;
    endproperty
    a_sel_one: assert property (p_sel_one) else $error("not one line per bank"); // R7

    property p_inhibit_off;
        !inhibit_timing_pulse |-> inhibit_drive == '0;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("inhibit outside pulse"); // R13

    property p_bus_idle;
        !bus_drive_en |-> bus_data_oe == '0;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("bus driven without enable"); // R11

    property p_clear_first;
        $rose(sense_strobe) |-> st_reg.data == '0;
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("strobe before clear"); // R9

    property p_load_once;
        data_load_pulse |=> !data_load_pulse;
    endproperty
    a_load_once: assert property (p_load_once) else $error("load pulse too long"); // R16

    c_read: cover property ($fell(bus_drive_en) && !st_reg.cyc_wr);
    c_write: cover property ($fell(inhibit_timing_pulse) && st_reg.cyc_wr);
    c_sense: cover property (sense_strobe && sense_pulse != '0);
    c_err: cover property (pready && pslverr);
endmodule : cmw_word_access
`default_nettype wire

// *** sim/cmw_bus_requester.sv ***
/*
 * requesting bus master model: pulls the inverted bus lines for a write cycle
 * and takes the word the memory drives during a read/restore cycle.
 * assumes pull-ups on every bus line.
 */
`timescale 1ns/100ps
`default_nettype none
module cmw_bus_requester
    import cmw_pkg::*;
(
    input wire logic pclk,
    input wire logic drive_on,
    input wire logic [WORD_W-1:0] drive_word,
    input wire logic [WORD_W-1:0] mem_oe,
    input wire logic [WORD_W-1:0] mem_out,
    input wire logic mem_drive_en,
    output logic [WORD_W-1:0] line_n,
    output logic [WORD_W-1:0] read_word
);
    // requester pulls data lines
    // released lines float high, so a stale value never shows
    assign line_n = ~((mem_oe & ~mem_out) | (drive_on ? drive_word : '0));
    always_ff @(posedge pclk) begin
        if (mem_drive_en) begin
            read_word <= ~line_n;
        end
    end
endmodule : cmw_bus_requester
`default_nettype wire

// *** sim/test_cmw_word_access.sv ***
/*
 * self-checking bench of the word access block over APB, with the bus model.
 * assumes short phase counts; sense input stands in for the core stack.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module test_cmw_word_access;
    import cmw_pkg::*;
    localparam int N_CLR = 1;
    localparam int N_STB = 5;
    localparam int N_RD = 4;
    localparam int N_WR = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drive_on = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, rsn, agp, clr, stb, ldp, itp, bde;
    logic [15:0] bus_n, bus_out, bus_oe, sense, inh, pat = '0, drv = '0, req_word;
    logic [DEC_N-1:0][7:0] sel, rd_snap, wr_snap, keep_snap;
    int mismatches = 0, n_checks = 0;
    // lines that are not strobed carry the opposite pattern
    assign sense = stb ? pat : ~pat;
    cmw_word_access #(.CLEAR_CYCLES(N_CLR), .READ_CYCLES(N_RD), .STROBE_CYCLES(N_STB),
        .WRITE_CYCLES(N_WR)) u_cmw_word_access (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_data_n_in(bus_n), .bus_data_out(bus_out),
        .bus_data_oe(bus_oe), .sense_pulse(sense), .inhibit_drive(inh), .read_sel_n(rsn),
        .address_gate_pulse(agp), .data_clear_pulse(clr), .sense_strobe(stb),
        .data_load_pulse(ldp), .inhibit_timing_pulse(itp), .bus_drive_en(bde),
        .sel_lines_n(sel));
    cmw_bus_requester u_cmw_bus_requester (.pclk(pclk), .drive_on(drive_on),
        .drive_word(drv), .mem_oe(bus_oe), .mem_out(bus_out), .mem_drive_en(bde),
        .line_n(bus_n), .read_word(req_word));
    // ---------------------------------------------------------
    // bus and sequencing tasks
    // ---------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the slave
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    function automatic logic [11:0] grp(input logic [DEC_N-1:0][7:0] s, input int b, n);
        logic [7:0] m;
        logic [3:0] c;
        m = 8'hff;
        c = '0;
        for (int i = 0; i < n; i++) begin
            m &= s[b+i];
            c += 4'(s[b+i] != 8'hff);
        end
        return {c, m};
    endfunction : grp
    task automatic run(input logic wr, big, input logic [13:0] a, input logic [15:0] w);
        int nc, ns, nl, ng, rc, wc, base[4], nd[4], lsb[4];
        logic bad, seen, prsn;
        logic [1:0] d;
        base = '{0, YD_BASE, XS_BASE, XD_BASE}; nd = '{2, 2, 4, 2};
        lsb = '{YS_D_LSB, YD_D_LSB, XS_D_LSB, XD_D_LSB};
        nc = 0; ns = 0; nl = 0; rc = 0; wc = 0; bad = 0; seen = 0; prsn = 1;
        ng = 0;
        pat <= wr ? ~w : w;
        drv <= w;
        drive_on <= wr;
        apb(1'b1, ADDR_OFF, {18'h0, a});
        apb(1'b1, CTRL_OFF, {29'h0, big, wr, 1'b1});
        for (int k = 0; k < 200 && !(seen && !itp); k++) begin
            @(posedge pclk);
            nc += int'(clr); nl += int'(ldp);
            ng += int'(agp);
            bad |= stb && nc == 0;
            ns += int'(stb);
            seen |= itp;
            rc = rsn ? 0 : rc + 1;
            wc = itp ? wc + 1 : 0;
            if (rc == 3) rd_snap = sel;
            if (wc == 3) wr_snap = sel;
            if (itp) `CHK("inhibit", ~w, inh)
            if (!prsn && rsn) `CHK("restore", 1'b1, itp)
            prsn = rsn;
        end
        drive_on <= 1'b0;
        `CHK("finished", 1'b1, seen && !itp)
        `CHK("gate", N_RD + N_WR + (wr ? 0 : N_STB), ng)
        `CHK("clears", wr ? 0 : N_CLR, nc)
        `CHK("strobes", wr ? 0 : N_STB, ns)
        `CHK("loads", int'(wr), nl)
        `CHK("order", 1'b0, bad)
        apb(1'b0, DATA_OFF, '0);
        `CHK("data", {16'h0, w}, rd)
        apb(1'b0, STAT_OFF, '0);
        `CHK("status", 2'b10, rd[1:0])
        if (!wr) `CHK("bus word", w, req_word)
        for (int g = 0; g < 4; g++) begin
            d = a[lsb[g]+1 +: 2];
            `CHK("read sel", {4'h1, ~(8'h01 << d)}, grp(rd_snap, base[g], nd[g]))
            `CHK("write sel", {4'h1, ~(8'h10 << d)}, grp(wr_snap, base[g], nd[g]))
        end
    endtask : run
    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic t_idle_unmapped;
        `CHK("idle sel", {DEC_N{8'hff}}, sel)
        `CHK("idle read sel", 1'b1, rsn)
        `CHK("idle gate", 1'b0, agp)
        apb(1'b0, 8'h10, '0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
    endtask : t_idle_unmapped
    task automatic t_read_restore;
        run(1'b0, 1'b1, 14'h1ffa, 16'ha5c3);
        run(1'b0, 1'b1, 14'h0554, 16'h0000);
    endtask : t_read_restore
    task automatic t_size_4k;
        run(1'b0, 1'b1, 14'h0ff4, 16'h8001);
        keep_snap = rd_snap;
        run(1'b0, 1'b0, 14'h2ff4, 16'h8001);
        `CHK("4k sel", keep_snap, rd_snap)
    endtask : t_size_4k
    task automatic t_write;
        run(1'b1, 1'b1, 14'h2aaa, 16'h3c96);
        run(1'b1, 1'b1, 14'h1556, 16'hffff);
    endtask : t_write
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        forever #2 pclk = ~pclk;
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_idle_unmapped();
        t_read_restore();
        t_size_4k();
        t_write();
        finish_test();
    end
endmodule : test_cmw_word_access
`default_nettype wire
